/* hw/aacr_pkg.sv */
package aacr_pkg;

  // register address map, word index on the control port
  localparam logic [5:0] OFS_RESET_ID  = 6'h00;
  localparam logic [5:0] OFS_LINE      = 6'h02;
  localparam logic [5:0] OFS_SPK       = 6'h03;
  localparam logic [5:0] OFS_REF       = 6'h04;
  localparam logic [5:0] OFS_BIAS      = 6'h05;
  localparam logic [5:0] OFS_MIX       = 6'h07;
  localparam logic [5:0] OFS_POP       = 6'h08;
  localparam logic [5:0] OFS_BOOST     = 6'h09;
  localparam logic [5:0] OFS_SPK_MODE  = 6'h0A;
  localparam logic [5:0] OFS_PWR       = 6'h0B;
  localparam logic [5:0] OFS_CLK_DIV   = 6'h0C;
  localparam logic [5:0] OFS_RATE      = 6'h0D;
  localparam logic [5:0] OFS_CLK_EN    = 6'h0E;
  localparam logic [5:0] OFS_LOOP_A    = 6'h10;
  localparam logic [5:0] OFS_LOOP_B    = 6'h11;
  localparam logic [5:0] OFS_LOOP_FRAC = 6'h12;
  localparam logic [5:0] OFS_LOOP_INT  = 6'h13;
  localparam logic [5:0] OFS_LOOP_REF  = 6'h14;
  localparam logic [5:0] OFS_PORT_SET  = 6'h15;
  localparam logic [5:0] OFS_AUD_A     = 6'h16;
  localparam logic [5:0] OFS_AUD_B     = 6'h17;
  localparam logic [5:0] OFS_AUD_C     = 6'h18;
  localparam logic [5:0] OFS_AUD_D     = 6'h19;
  localparam logic [5:0] OFS_FLAGS     = 6'h1A;
  localparam logic [5:0] OFS_MASKS     = 6'h1B;
  localparam logic [5:0] OFS_EVT_POL   = 6'h1C;
  localparam logic [5:0] OFS_EVT_PIN   = 6'h1D;
  localparam logic [5:0] OFS_CONV_VOL  = 6'h1E;
  localparam logic [5:0] OFS_CONV_MUTE = 6'h1F;
  localparam logic [5:0] OFS_RANGE_A   = 6'h20;
  localparam logic [5:0] OFS_RANGE_D   = 6'h23;
  localparam logic [5:0] OFS_SEQ       = 6'h26;
  localparam logic [5:0] OFS_EQ_FIRST  = 6'h2A;
  localparam logic [5:0] OFS_EQ_LAST   = 6'h3D;

  // field positions
  localparam int unsigned MUTE_BIT      = 7;
  localparam int unsigned CROSS_BIT     = 6;
  localparam int unsigned GAIN_LSB      = 0;
  localparam int unsigned GAIN_W        = 6;
  localparam int unsigned REF_BUF_BIT   = 5;
  localparam int unsigned REF_SOFT_BIT  = 3;
  localparam int unsigned REF_DIV_LSB   = 1;
  localparam int unsigned REF_SLEW_BIT  = 0;
  localparam int unsigned BIAS_SOURCE_SELECT_BIT  = 6;
  localparam int unsigned STBY_LVL_BIT  = 5;
  localparam int unsigned STBY_SEL_BIT  = 4;
  localparam int unsigned MASTER_BIAS_LEVEL_LSB  = 2;
  localparam int unsigned BIAS_ON_BIT   = 1;
  localparam int unsigned START_ON_BIT  = 0;
  localparam int unsigned CONV_PATH_BIT = 4;
  localparam int unsigned IN2_ATT_BIT   = 3;
  localparam int unsigned IN2_ON_BIT    = 2;
  localparam int unsigned IN1_ATT_BIT   = 1;
  localparam int unsigned IN1_ON_BIT    = 0;
  localparam int unsigned TEMP_BIT      = 6;
  localparam int unsigned SEQ_FLAG_BIT  = 2;
  localparam int unsigned TSHUT_FLAG_BIT = 0;

  localparam logic [5:0]  GAIN_0DB      = 6'h39;
  localparam logic [15:0] ID_NEUTRAL    = 16'h5A3C; // arbitrary value

  typedef logic [15:0] aacr_word_t;

  // power-on and soft-reset contents of each word
  localparam aacr_word_t RESET_TBL [0:63] = '{
    OFS_LINE: 16'h00B9, OFS_SPK: 16'h00B9, OFS_REF: 16'h0001,
    OFS_BIAS: 16'h0068, OFS_BOOST: 16'h01DB, OFS_SPK_MODE: 16'h0018,
    OFS_PWR: 16'h0180, OFS_RATE: 16'h0038, OFS_LOOP_B: 16'h0200,
    OFS_LOOP_INT: 16'h0204, OFS_PORT_SET: 16'h0002, OFS_AUD_B: 16'h0002,
    OFS_AUD_D: 16'h0022, OFS_MASKS: 16'h0006, OFS_CONV_VOL: 16'h00C0,
    OFS_CONV_MUTE: 16'h0008, OFS_RANGE_A: 16'h09AF, 6'h21: 16'h4201,
    6'h2C: 16'h0FCA, 6'h2D: 16'h0400, 6'h2E: 16'h00B8, 6'h2F: 16'h1EB5,
    6'h30: 16'hF145, 6'h31: 16'h0B75, 6'h32: 16'h01C5, 6'h33: 16'h169E,
    6'h34: 16'hF829, 6'h35: 16'h07AD, 6'h36: 16'h1103, 6'h37: 16'h1C58,
    6'h38: 16'hF373, 6'h39: 16'h0A54, 6'h3A: 16'h0558, 6'h3B: 16'h0564,
    6'h3C: 16'h0559, OFS_EQ_LAST: 16'h4000,
    default: 16'h0000
  };

  // bits that software may write; zero entries other than word zero are not mapped
  localparam aacr_word_t WMASK_TBL [0:63] = '{
    OFS_LINE: 16'h00FF, OFS_SPK: 16'h00FF, OFS_REF: 16'h002F,
    OFS_BIAS: 16'h007F, OFS_MIX: 16'h001F, OFS_POP: 16'h0007,
    OFS_BOOST: 16'h003F, OFS_SPK_MODE: 16'h0058, OFS_PWR: 16'h0197,
    OFS_CLK_DIV: 16'h1F80, OFS_RATE: 16'h00FF, OFS_CLK_EN: 16'h2027,
    OFS_LOOP_A: 16'h000D, OFS_LOOP_B: 16'h0777, OFS_LOOP_FRAC: 16'hFFFF,
    OFS_LOOP_INT: 16'h7FEF, OFS_LOOP_REF: 16'h001B, OFS_PORT_SET: 16'h003A,
    OFS_AUD_A: 16'hFFFF, OFS_AUD_B: 16'hFFFF, OFS_AUD_C: 16'hFFFF,
    OFS_AUD_D: 16'hFFFF, OFS_FLAGS: 16'h0005, OFS_MASKS: 16'h0005,
    OFS_EVT_POL: 16'h0001, OFS_EVT_PIN: 16'h8001, OFS_CONV_VOL: 16'h00FF,
    OFS_CONV_MUTE: 16'hFFFF, OFS_RANGE_A: 16'hFFFF, 6'h21: 16'hFFFF,
    6'h22: 16'hFFFF, OFS_RANGE_D: 16'hFFFF, OFS_SEQ: 16'hFFFF,
    OFS_EQ_FIRST: 16'hFFFF, 6'h2B: 16'hFFFF, 6'h2C: 16'hFFFF,
    6'h2D: 16'hFFFF, 6'h2E: 16'hFFFF, 6'h2F: 16'hFFFF, 6'h30: 16'hFFFF,
    6'h31: 16'hFFFF, 6'h32: 16'hFFFF, 6'h33: 16'hFFFF, 6'h34: 16'hFFFF,
    6'h35: 16'hFFFF, 6'h36: 16'hFFFF, 6'h37: 16'hFFFF, 6'h38: 16'hFFFF,
    6'h39: 16'hFFFF, 6'h3A: 16'hFFFF, 6'h3B: 16'hFFFF, 6'h3C: 16'hFFFF,
    OFS_EQ_LAST: 16'hFFFF,
    default: 16'h0000
  };

  typedef enum logic [1:0] {
    AACR_REF_OFF,
    AACR_REF_NORMAL,
    AACR_REF_STANDBY,
    AACR_REF_FAST
  } aacr_ref_e;

  typedef enum logic [2:0] {
    AACR_BIAS_X050,
    AACR_BIAS_X075,
    AACR_BIAS_X100,
    AACR_BIAS_X150,
    AACR_BIAS_X025
  } aacr_bias_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    aacr_word_t wdata;
  } aacr_req_s;

  typedef struct packed {
    logic       line_output_silence;
    logic       line_output_crossing_update;
    logic       speaker_amp_silence;
    logic       speaker_amp_crossing_update;
    aacr_ref_e  reference_divider_select;
    logic       reference_soft_start;
    logic       reference_slew_fast;
    logic       buffered_reference_on;
    logic       bias_source_select;
    aacr_bias_e master_bias_level;
    logic       normal_bias_on;
    logic       startup_bias_on;
    logic       converter_path_on;
    logic       first_input_on;
    logic       first_input_attenuate;
    logic       second_input_on;
    logic       second_input_attenuate;
  } aacr_analog_s;

endpackage

/* hw/aacr_gain_hold.sv */
`timescale 1ns/1ps
`default_nettype none

// holds the applied gain; either follows at once or waits for a crossing
module aacr_gain_hold #(
  parameter int unsigned W          = 6,
  parameter logic [W-1:0] RESET_CODE = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         reload,
  input  wire logic         crossing_mode,
  input  wire logic         zero_cross,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] applied
);

  // take the new code now, or only on a zero crossing pulse
  wire take = !crossing_mode || zero_cross;

  always_ff @(posedge clk)
  begin
    if (rst || reload)
      applied <= RESET_CODE;
    else if (take)
      applied <= target;
  end

endmodule

`default_nettype wire

/* hw/aacr_top.sv */
`timescale 1ns/1ps
`default_nettype none

module aacr_top #(
  parameter logic [15:0] ID_CODE = aacr_pkg::ID_NEUTRAL
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire aacr_pkg::aacr_req_s  req,
  input  wire logic                 line_zero_cross,
  input  wire logic                 spk_zero_cross,
  input  wire logic                 seq_done_evt,
  input  wire logic                 tshut_evt,
  input  wire logic                 temp_limit,
  output logic [15:0]               rd_data,
  output logic                      rd_valid,
  output var aacr_pkg::aacr_analog_s analog,
  output logic [5:0]                line_output_gain,
  output logic [5:0]                speaker_amp_gain
);

  // a word is mapped when it has writable bits, or is word zero
  function automatic logic addr_mapped(input logic [6:0] a);
    logic [5:0] i;
    i = a[5:0];
    addr_mapped = !a[6] &&
      ((aacr_pkg::WMASK_TBL[i] != 16'h0000) ||
       (i == aacr_pkg::OFS_RESET_ID));
  endfunction

  // effective master bias from the bias word
  function automatic aacr_pkg::aacr_bias_e bias_decode(
    input logic [15:0] w
  );
    logic [1:0] lvl;
    lvl = w[aacr_pkg::MASTER_BIAS_LEVEL_LSB +: 2];
    if (w[aacr_pkg::STBY_SEL_BIT])
      bias_decode = w[aacr_pkg::STBY_LVL_BIT] ?
                    aacr_pkg::AACR_BIAS_X025 :
                    aacr_pkg::AACR_BIAS_X050;
    else
    begin
      unique case (lvl)
        2'b00: bias_decode = aacr_pkg::AACR_BIAS_X050;
        2'b01: bias_decode = aacr_pkg::AACR_BIAS_X075;
        2'b10: bias_decode = aacr_pkg::AACR_BIAS_X100;
        2'b11: bias_decode = aacr_pkg::AACR_BIAS_X150;
      endcase
    end
  endfunction

  // turns the stored words into the analogue control set
  function automatic aacr_pkg::aacr_analog_s analog_decode(
    input logic [15:0] line_w,
    input logic [15:0] spk_w,
    input logic [15:0] ref_w,
    input logic [15:0] bias_w,
    input logic [15:0] mix_w
  );
    aacr_pkg::aacr_analog_s a;
    a = '0;
    a.line_output_silence         = line_w[aacr_pkg::MUTE_BIT];
    a.line_output_crossing_update = line_w[aacr_pkg::CROSS_BIT];
    a.speaker_amp_silence         = spk_w[aacr_pkg::MUTE_BIT];
    a.speaker_amp_crossing_update = spk_w[aacr_pkg::CROSS_BIT];
    a.reference_divider_select    = aacr_pkg::aacr_ref_e'(
      ref_w[aacr_pkg::REF_DIV_LSB +: 2]);
    a.reference_soft_start  = ref_w[aacr_pkg::REF_SOFT_BIT];
    a.reference_slew_fast   = ref_w[aacr_pkg::REF_SLEW_BIT];
    a.buffered_reference_on = ref_w[aacr_pkg::REF_BUF_BIT];
    a.bias_source_select    = bias_w[aacr_pkg::BIAS_SOURCE_SELECT_BIT];
    a.master_bias_level     = bias_decode(bias_w);
    a.normal_bias_on        = bias_w[aacr_pkg::BIAS_ON_BIT];
    a.startup_bias_on       = bias_w[aacr_pkg::START_ON_BIT];
    a.converter_path_on     = mix_w[aacr_pkg::CONV_PATH_BIT];
    a.first_input_on        = mix_w[aacr_pkg::IN1_ON_BIT];
    a.first_input_attenuate = mix_w[aacr_pkg::IN1_ATT_BIT];
    a.second_input_on       = mix_w[aacr_pkg::IN2_ON_BIT];
    a.second_input_attenuate = mix_w[aacr_pkg::IN2_ATT_BIT];
    analog_decode = a;
  endfunction

  logic [15:0] regs_r   [0:63];
  logic [15:0] reg_nxt  [0:63];
  logic        temp_r;

  // request decode
  wire [5:0]  idx      = req.addr[5:0];
  wire        mapped   = addr_mapped(req.addr);
  wire        wr_ok    = req.wr && mapped;
  wire        soft_rst = wr_ok && (idx == aacr_pkg::OFS_RESET_ID);
  wire [15:0] set_vec  =
    (16'h0001 << aacr_pkg::SEQ_FLAG_BIT)   & {16{seq_done_evt}} |
    (16'h0001 << aacr_pkg::TSHUT_FLAG_BIT) & {16{tshut_evt}};

  // next value of every stored word
  genvar g;
  generate
    for (g = 0; g < 64; g++)
    begin : g_word
      localparam logic [5:0] GI = 6'(g);
      wire        hit  = wr_ok && (idx == GI);
      wire [15:0] msk  = aacr_pkg::WMASK_TBL[g];
      wire [15:0] wbit = req.wdata & msk;
      if (GI == aacr_pkg::OFS_FLAGS)
      begin : g_flags
        // sticky flags: one clears, a new event wins over the clear
        wire [15:0] clr = hit ? wbit : 16'h0000;
        assign reg_nxt[g] = soft_rst ? (set_vec & msk) :
                            ((regs_r[g] & ~clr) | (set_vec & msk));
      end
      else
      begin : g_plain
        assign reg_nxt[g] = soft_rst ? aacr_pkg::RESET_TBL[g] :
                            hit ? ((regs_r[g] & ~msk) | wbit) :
                            regs_r[g];
      end

      always_ff @(posedge clk)
      begin
        if (rst)
          regs_r[g] <= aacr_pkg::RESET_TBL[g];
        else
          regs_r[g] <= reg_nxt[g];
      end
    end
  endgenerate

  // read data selection
  wire [15:0] temp_word = {15'h0000, temp_r} << aacr_pkg::TEMP_BIT;
  wire [15:0] rd_word   =
    !mapped                              ? 16'h0000 :
    (idx == aacr_pkg::OFS_RESET_ID)      ? ID_CODE :
    (idx == aacr_pkg::OFS_PWR)           ? (regs_r[idx] | temp_word) :
                                           regs_r[idx];

  // analogue controls decoded from the current words
  wire aacr_pkg::aacr_analog_s analog_nxt = analog_decode(
    regs_r[aacr_pkg::OFS_LINE], regs_r[aacr_pkg::OFS_SPK],
    regs_r[aacr_pkg::OFS_REF], regs_r[aacr_pkg::OFS_BIAS],
    regs_r[aacr_pkg::OFS_MIX]);
  wire aacr_pkg::aacr_analog_s analog_rst = analog_decode(
    aacr_pkg::RESET_TBL[aacr_pkg::OFS_LINE],
    aacr_pkg::RESET_TBL[aacr_pkg::OFS_SPK],
    aacr_pkg::RESET_TBL[aacr_pkg::OFS_REF],
    aacr_pkg::RESET_TBL[aacr_pkg::OFS_BIAS],
    aacr_pkg::RESET_TBL[aacr_pkg::OFS_MIX]);

  // gain targets and update modes
  wire [5:0] line_target =
    regs_r[aacr_pkg::OFS_LINE][aacr_pkg::GAIN_LSB +: aacr_pkg::GAIN_W];
  wire [5:0] spk_target  =
    regs_r[aacr_pkg::OFS_SPK][aacr_pkg::GAIN_LSB +: aacr_pkg::GAIN_W];
  wire       line_cross  = regs_r[aacr_pkg::OFS_LINE][aacr_pkg::CROSS_BIT];
  wire       spk_cross   = regs_r[aacr_pkg::OFS_SPK][aacr_pkg::CROSS_BIT];

  // read port, status sample and analogue outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
      temp_r   <= 1'b0;
      analog   <= analog_rst;
    end
    else
    begin
      rd_valid <= req.rd;
      if (req.rd)
        rd_data <= rd_word;
      temp_r   <= temp_limit;
      analog   <= analog_nxt;
    end
  end

  // line output gain, 1 dB per code, 0 dB at 39h
  aacr_gain_hold #(
    .W          (aacr_pkg::GAIN_W),
    .RESET_CODE (aacr_pkg::GAIN_0DB)
  ) u_line_gain (
    .clk           (clk),
    .rst           (rst),
    .reload        (soft_rst),
    .crossing_mode (line_cross),
    .zero_cross    (line_zero_cross),
    .target        (line_target),
    .applied       (line_output_gain)
  );

  // speaker amplifier gain, same coding
  aacr_gain_hold #(
    .W          (aacr_pkg::GAIN_W),
    .RESET_CODE (aacr_pkg::GAIN_0DB)
  ) u_spk_gain (
    .clk           (clk),
    .rst           (rst),
    .reload        (soft_rst),
    .crossing_mode (spk_cross),
    .zero_cross    (spk_zero_cross),
    .target        (spk_target),
    .applied       (speaker_amp_gain)
  );

  // soft reset brings bias word back, seen by a following read
  property p_soft_reset;
    @(posedge clk) disable iff (rst)
    (req.wr && req.addr == 7'h00) ##1
    (req.rd && req.addr == {1'b0, aacr_pkg::OFS_BIAS})
    |=> rd_data == aacr_pkg::RESET_TBL[aacr_pkg::OFS_BIAS];
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore bias word");

  // soft reset mutes both stages two cycles later
  property p_soft_mute;
    @(posedge clk) disable iff (rst)
    (req.wr && req.addr == 7'h00) |=> ##1
    (analog.line_output_silence && analog.speaker_amp_silence &&
     analog.reference_divider_select == aacr_pkg::AACR_REF_OFF);
  endproperty
  a_soft_mute: assert property (p_soft_mute)
    else $error("soft reset left an output unmuted");

  // identity read
  property p_identity;
    @(posedge clk) disable iff (rst)
    (req.rd && req.addr == 7'h00) |=> (rd_valid && rd_data == ID_CODE);
  endproperty
  a_identity: assert property (p_identity)
    else $error("word zero did not read identity code");

  // immediate mode: applied gain tracks target next cycle
  property p_line_now;
    @(posedge clk) disable iff (rst)
    (!line_cross && !soft_rst) |=> line_output_gain == $past(line_target);
  endproperty
  a_line_now: assert property (p_line_now)
    else $error("line gain not applied at once");

  // crossing mode: gain holds until a crossing pulse
  property p_spk_hold;
    @(posedge clk) disable iff (rst)
    (spk_cross && !spk_zero_cross && !soft_rst) |=>
    $stable(speaker_amp_gain);
  endproperty
  a_spk_hold: assert property (p_spk_hold)
    else $error("speaker gain changed without crossing");

  // gains come out of reset at 0 dB
  property p_gain_reset;
    @(posedge clk)
    $fell(rst) |-> (line_output_gain == aacr_pkg::GAIN_0DB &&
                    speaker_amp_gain == aacr_pkg::GAIN_0DB);
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain not at 0 dB after reset");

  // standby select with the level bit set chooses the quarter level
  property p_standby_bias;
    @(posedge clk) disable iff (rst)
    (regs_r[aacr_pkg::OFS_BIAS][aacr_pkg::STBY_SEL_BIT] &&
     regs_r[aacr_pkg::OFS_BIAS][aacr_pkg::STBY_LVL_BIT])
    |=> analog.master_bias_level == aacr_pkg::AACR_BIAS_X025;
  endproperty
  a_standby_bias: assert property (p_standby_bias)
    else $error("standby bias level not selected");

  // converter path follows its bit
  property p_conv_path;
    @(posedge clk) disable iff (rst)
    1'b1 |=> analog.converter_path_on ==
             $past(regs_r[aacr_pkg::OFS_MIX][aacr_pkg::CONV_PATH_BIT]);
  endproperty
  a_conv_path: assert property (p_conv_path)
    else $error("converter path enable mismatch");

  // a new event survives a same-cycle clear
  property p_flag_set_wins;
    @(posedge clk) disable iff (rst)
    tshut_evt |=>
    regs_r[aacr_pkg::OFS_FLAGS][aacr_pkg::TSHUT_FLAG_BIT];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("thermal flag lost");

  // fixed-zero bits of the line word read zero
  property p_fixed_zero;
    @(posedge clk) disable iff (rst)
    (req.rd && req.addr == {1'b0, aacr_pkg::OFS_LINE}) |=>
    rd_data[15:8] == 8'h00;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("fixed bits read nonzero");

  // unmapped read returns zero, unmapped write leaves the line word unchanged
  property p_unmapped;
    @(posedge clk) disable iff (rst)
    ((req.rd || req.wr) && !mapped) |=>
    ((!$past(req.rd) || rd_data == 16'h0000) &&
     $stable(regs_r[aacr_pkg::OFS_LINE]));
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access had an effect");

  // line mute follows its bit one cycle later
  property p_line_mute;
    @(posedge clk) disable iff (rst)
    1'b1 |=> analog.line_output_silence ==
             $past(regs_r[aacr_pkg::OFS_LINE][aacr_pkg::MUTE_BIT]);
  endproperty
  a_line_mute: assert property (p_line_mute)
    else $error("line mute does not follow its bit");

  // speaker mute follows its bit one cycle later
  property p_spk_mute;
    @(posedge clk) disable iff (rst)
    1'b1 |=> analog.speaker_amp_silence ==
             $past(regs_r[aacr_pkg::OFS_SPK][aacr_pkg::MUTE_BIT]);
  endproperty
  a_spk_mute: assert property (p_spk_mute)
    else $error("speaker mute does not follow its bit");

endmodule

`default_nettype wire

/* bench/aacr_host.sv */
`timescale 1ns/1ps
`default_nettype none

// register port master; changes its request at falling edges only
module aacr_host (
  input  wire logic                 clk,
  input  wire logic [15:0]          rd_data,
  input  wire logic                 rd_valid,
  output var  aacr_pkg::aacr_req_s  req
);
  initial req = '0;

  // one-cycle write strobe, then a settle cycle for the decode
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // released: junk
    @(negedge clk);
  endtask

  // one-cycle read strobe; answer stands the following cycle
  task automatic rd(input logic [6:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hA5C3};
    @(negedge clk);
    d = rd_data;
    v = rd_valid;
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h5A3C};
  endtask

  // write, then a read on the very next cycle, back to back
  task automatic wr_rd(input logic [6:0] wa, input logic [15:0] wd,
                       input logic [6:0] ra, output logic [15:0] d,
                       output logic v);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: wa, wdata: wd};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ra, wdata: 16'hA5C3};
    @(negedge clk);
    d = rd_data;
    v = rd_valid;
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~ra, wdata: 16'h5A3C};
  endtask
endmodule

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define chk(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end

module tb;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   lzc = 1'b0;
  logic                   szc = 1'b0;
  logic                   seq_e = 1'b0;
  logic                   tsh_e = 1'b0;
  logic                   temp = 1'b0;
  aacr_pkg::aacr_req_s    req;
  logic [15:0]            rd_data;
  logic                   rd_valid;
  aacr_pkg::aacr_analog_s an;
  logic [5:0]             lg;
  logic [5:0]             sg;
  int                     n_errors = 0;
  int                     total_checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  aacr_host host_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
                    .req(req));
  aacr_top dut_u (.clk(clk), .rst(rst), .req(req), .line_zero_cross(lzc),
                  .spk_zero_cross(szc), .seq_done_evt(seq_e),
                  .tshut_evt(tsh_e), .temp_limit(temp), .rd_data(rd_data),
                  .rd_valid(rd_valid), .analog(an), .line_output_gain(lg),
                  .speaker_amp_gain(sg));

  // read one word and compare with its expected contents
  task automatic chk_rd(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    host_u.rd(a, d, v);
    `chk("rd_valid", 1'b1, v);
    `chk("rd_data", e, d);
  endtask

  // contents and decode straight after reset
  task automatic t_defaults;
    chk_rd(7'h00, aacr_pkg::ID_NEUTRAL);
    chk_rd(7'h02, 16'h00B9);
    chk_rd(7'h03, 16'h00B9);
    chk_rd(7'h04, 16'h0001);
    chk_rd(7'h05, 16'h0068);
    chk_rd(7'h07, 16'h0000);
    `chk("lmute", 1'b1, an.line_output_silence);
    `chk("smute", 1'b1, an.speaker_amp_silence);
    `chk("refdiv", 2'h0, an.reference_divider_select);
    `chk("slew", 1'b1, an.reference_slew_fast);
    `chk("bsrc", 1'b1, an.bias_source_select);
    `chk("mbias", 3'h2, an.master_bias_level);
    `chk("lgain", 6'h39, lg);
    `chk("sgain", 6'h39, sg);
    `chk("ins on", 2'h0, {an.first_input_on, an.second_input_on});
  endtask

  // reference and bias fields, every code of both 2-bit fields
  task automatic t_ref_bias;
    host_u.wr(7'h04, 16'hFFFF);
    chk_rd(7'h04, 16'h002F);
    `chk("soft", 1'b1, an.reference_soft_start);
    `chk("buf", 1'b1, an.buffered_reference_on);
    for (int i = 0; i < 4; i++)
    begin
      host_u.wr(7'h04, 16'(i << 1));
      `chk("refdiv", i[1:0], an.reference_divider_select);
      `chk("slew", 1'b0, an.reference_slew_fast);
      host_u.wr(7'h05, 16'h0002 | 16'(i << 2));
      `chk("mbias", 3'(i), an.master_bias_level);
      `chk("bon", 1'b1, an.normal_bias_on);
      `chk("son", 1'b0, an.startup_bias_on);
      `chk("bsrc", 1'b0, an.bias_source_select);
    end
    host_u.wr(7'h05, 16'h0071);
    `chk("quarter", 3'h4, an.master_bias_level);
    `chk("son", 1'b1, an.startup_bias_on);
    host_u.wr(7'h05, 16'h0011);
    `chk("half", 3'h0, an.master_bias_level);
    host_u.wr(7'h05, 16'hFFFF);
    chk_rd(7'h05, 16'h007F);
    host_u.wr(7'h07, 16'hFFFF);
    chk_rd(7'h07, 16'h001F);
    `chk("conv", 1'b1, an.converter_path_on);
    `chk("att", 2'h3, {an.first_input_attenuate,
                      an.second_input_attenuate});
    `chk("ins on", 2'h3, {an.first_input_on, an.second_input_on});
    host_u.wr(7'h07, 16'h0005);
    `chk("conv", 1'b0, an.converter_path_on);
    `chk("att", 2'h0, {an.first_input_attenuate,
                      an.second_input_attenuate});
  endtask

  // immediate gain change, then one held until a crossing pulse
  task automatic t_gain(input logic s);
    host_u.wr(7'h02 + 7'(s), 16'h0010);
    `chk("zc mode", 1'b0, s ? an.speaker_amp_crossing_update
                            : an.line_output_crossing_update);
    `chk("gain now", 6'h10, s ? sg : lg);
    `chk("unmute", 1'b0, s ? an.speaker_amp_silence
                           : an.line_output_silence);
    host_u.wr(7'h02 + 7'(s), 16'h00C3);
    `chk("zc mode", 1'b1, s ? an.speaker_amp_crossing_update
                            : an.line_output_crossing_update);
    `chk("gain held", 6'h10, s ? sg : lg);
    @(negedge clk);
    if (s) szc = 1'b1; else lzc = 1'b1;
    @(negedge clk);
    szc = 1'b0;
    lzc = 1'b0;
    `chk("gain cross", 6'h03, s ? sg : lg);
  endtask

  // sticky event flags, write-one-to-clear, status bit
  task automatic t_events;
    temp = 1'b1;
    chk_rd(7'h0B, 16'h01C0);
    @(negedge clk);
    tsh_e = 1'b1;
    seq_e = 1'b1;
    @(negedge clk);
    tsh_e = 1'b0;
    seq_e = 1'b0;
    chk_rd(7'h1A, 16'h0005);
    host_u.wr(7'h1A, 16'h0000);
    chk_rd(7'h1A, 16'h0005);
    host_u.wr(7'h1A, 16'h0001);
    chk_rd(7'h1A, 16'h0004);
    host_u.wr(7'h1A, 16'h0004);
    chk_rd(7'h1A, 16'h0000);
    // event in the same cycle as a clear of its bit: the event wins
    fork
      host_u.wr(7'h1A, 16'h0001);
      begin
        @(negedge clk);
        tsh_e = 1'b1;
        @(negedge clk);
        tsh_e = 1'b0;
      end
    join
    chk_rd(7'h1A, 16'h0001);
  endtask

  // unmapped words, then soft reset through word zero
  task automatic t_unmapped_reset;
    logic [15:0] d;
    logic        v;
    host_u.wr(7'h01, 16'hFFFF);
    chk_rd(7'h01, 16'h0000);
    host_u.wr(7'h42, 16'hFFFF);
    chk_rd(7'h42, 16'h0000);
    chk_rd(7'h02, 16'h00C3);
    host_u.wr(7'h1B, 16'h0000);
    host_u.wr_rd(7'h00, 16'h1234, 7'h05, d, v);
    `chk("rd_valid", 1'b1, v);
    `chk("bias", 16'h0068, d);
    chk_rd(7'h02, 16'h00B9);
    chk_rd(7'h07, 16'h0000);
    chk_rd(7'h1B, 16'h0006);
    `chk("lgain", 6'h39, lg);
    `chk("lmute", 1'b1, an.line_output_silence);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog, far beyond the roughly 130 cycles the run needs
  initial
  begin
    #200000;
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_ref_bias();
    t_gain(1'b0);
    t_gain(1'b1);
    t_events();
    t_unmapped_reset();
    final_report();
  end
endmodule

`default_nettype wire
